// [loss_action_pkg.sv]
// Purpose: Shared constants and types for the network loss action block.
// Assumes: Register port with one-cycle read latency, 32-bit data.
// Notes:   Offsets are word indices times four; all values are plain defaults.
package loss_action_pkg;

  // Register byte offsets.
  localparam logic [7:0] ctrl_addr     = 8'h00;
  localparam logic [7:0] wdog_addr     = 8'h04;
  localparam logic [7:0] status_addr   = 8'h08;
  localparam logic [7:0] irq_stat_addr = 8'h0C;
  localparam logic [7:0] irq_mask_addr = 8'h10;
  localparam logic [7:0] param_sel_addr = 8'h14;
  localparam logic [7:0] param_dat_addr = 8'h18;

  // Control register fields.
  localparam int policy_lsb  = 0;
  localparam int action_lsb  = 4;
  localparam int eoff_lsb    = 12;
  localparam int boi_bit     = 16;
  localparam int reset_bit   = 17;

  // Reset values.
  localparam logic [1:0]  policy_reset = 2'h0;
  localparam logic [4:0]  action_reset = 5'h00;
  localparam logic [31:0] wdog_reset   = 32'h0007_A120;

  // Timeout policies.
  localparam logic [1:0] policy_timed_out = 2'h0;
  localparam logic [1:0] policy_delete    = 2'h1;
  localparam logic [1:0] policy_restart   = 2'h2;

  // Loss actions.
  localparam logic [4:0] act_zero   = 5'h00;
  localparam logic [4:0] act_retain = 5'h01;
  localparam logic [4:0] act_stop   = 5'h02;
  localparam logic [4:0] act_eoff   = 5'h03;
  localparam logic [4:0] act_preset_first = 5'h04;
  localparam logic [4:0] act_preset_last  = 5'h12;

  // Parameter object.
  localparam logic [7:0] param_class_code = 8'h0F;
  localparam logic [4:0] param_first      = 5'h01;
  localparam logic [4:0] param_last       = 5'h1D;

  // Interrupt bits.
  localparam int irq_timeout = 0;
  localparam int irq_fault   = 1;
  localparam int irq_applied = 2;
  localparam int irq_restore = 3;
  localparam int irq_width   = 4;

  // Consumed I/O data toward the drive.
  typedef struct packed {
    logic        run;
    logic        stop;
    logic        emergency_off;
    logic        preset_valid;
    logic [3:0]  preset_index;
    logic [15:0] freq_cmd;
    logic [15:0] cmd_word;
  } drive_cmd_t;

  typedef enum logic [1:0] {
    conn_established,
    conn_timed_out,
    conn_deleted
  } conn_state_t;

endpackage : loss_action_pkg

// [loss_action_sva.sv]
// Purpose: Port-level checks of the loss action block.
// Assumes: Bound to the top module; sees its ports only.
// Notes:   Policy and action fields are not tracked here, so checks are generic.
`timescale 1ns/1ps
module loss_action_sva (
  input wire logic                        sys_clk,
  input wire logic                        rst_n,
  input wire logic                        reg_read,
  input wire logic [31:0]                 reg_rdata,
  input wire logic                        net_rx_strobe,
  input wire loss_action_pkg::drive_cmd_t drive_cmd,
  input wire logic                        drive_cmd_active,
  input wire logic [1:0]                  conn_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_state_legal: assert property (conn_state != 2'h3)
    else $error("illegal connection state");
  a_timeout_acts: assert property ($rose(conn_state == 2'h1) |-> ##[0:2] drive_cmd_active)
    else $error("timed out without loss action");
  a_delete_acts: assert property ($rose(conn_state == 2'h2) |-> ##[0:2] drive_cmd_active)
    else $error("deleted without loss action");
  // A release must follow a fresh strobe, which stays high four cycles.
  a_release_by_data: assert property ($fell(drive_cmd_active) |-> conn_state == 2'h0 &&
    ($past(net_rx_strobe, 1) || $past(net_rx_strobe, 3) || $past(net_rx_strobe, 5)))
    else $error("loss released without fresh data");
  a_loss_held: assert property (drive_cmd_active && $past(drive_cmd_active) |-> $stable(drive_cmd))
    else $error("drive command moved during loss");
  a_preset_index: assert property (drive_cmd.preset_valid |-> drive_cmd.preset_index != 4'h0)
    else $error("preset index zero");
  a_preset_run: assert property ($rose(drive_cmd.preset_valid) |-> drive_cmd.run == $past(drive_cmd.run))
    else $error("preset changed run");
  a_stop_not_run: assert property (drive_cmd.stop |-> !drive_cmd.run)
    else $error("stop and run together");
endmodule : loss_action_sva

// [net_master.sv]
// Purpose: Polled I/O master model that delivers consumed data words.
// Assumes: One word per go pulse; a new go waits until the last one ends.
// Notes:   Data is inverted once its hold ends, so a late capture is visible.
`timescale 1ns/1ps
module net_master (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [31:0] word,
  output logic             net_rx_strobe,
  output logic [31:0]      net_data
);
  logic [2:0] cnt = 3'h0;
  initial begin
    net_rx_strobe = 1'b0;
    net_data = 32'h0;
  end
  // The strobe stays high for four cycles to outlast the input synchroniser.
  always @(posedge sys_clk) begin
    if (go) begin
      net_data <= word;
      net_rx_strobe <= 1'b1;
      cnt <= 3'h1;
    end else if (cnt != 3'h0) begin
      cnt <= cnt + 3'h1;
      if (cnt == 3'h4) net_rx_strobe <= 1'b0;
      if (cnt == 3'h6) begin
        net_data <= ~net_data;
        cnt <= 3'h0;
      end
    end
  end
endmodule : net_master

// [network_loss_action_control.sv]
// Purpose: Watches the polled I/O connection and network faults, applies timeout policy
//          and the selected failsafe action to data passed on to the drive.
// Assumes: Network inputs are asynchronous pins; drive side shares sys_clk.
// Notes:   The parameter object maps alias numbers to attribute values supplied by
//          other objects through param_values.
// Behaviour
// - Loss action applies on connection inactivity timeout and on fatal network fault.
// - Policy 0 puts the connection in timed-out state until reset or deletion.
// - Policy 1 deletes the connection automatically on watchdog expiry.
// - Policy 2 keeps the connection established and restarts the inactivity timer.
// - Loss action on timeout works under every policy value except 2 (0, 1 and 3); policy 2 keeps last conditions, but a fatal fault still applies it.
// - Action 0 forces consumed data to zero, stopping drive at zero frequency.
// - Action 1 keeps the most recently consumed data unchanged.
// - Action 2 issues a stop command to the drive.
// - Action 3 issues emergency off; drive reaction follows its own behaviour setting.
// - Actions 4 to 18 select preset speeds 1 to 15 in order.
// - Stop, emergency off and preset act only if network was command source at timeout.
// - Zeroed data stops the drive only when option interface is command source.
// - Preset actions leave the run and stop command unchanged.
// - Parameter object, class code 0x0F, aliases attributes of other objects.
// - Parameters 1 to 29 are supported, including bus-off behaviour and counter.
`timescale 1ns/1ps
module network_loss_action_control (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [31:0]                 reg_rdata,
  output logic                             irq,
  input  wire logic                        net_rx_strobe,
  input  wire logic                        net_fatal_fault,
  input  wire logic [31:0]                 net_data,
  input  wire logic                        net_is_cmd_source,
  input  wire logic                        option_cmd_mode,
  input  wire logic [29*16-1:0]            param_values,
  output loss_action_pkg::drive_cmd_t      drive_cmd,
  output logic                             drive_cmd_active,
  output logic [1:0]                       emergency_off_behavior_select,
  output logic                             bus_off_interrupt_behavior,
  output logic [1:0]                       conn_state
);

  localparam int irq_width_c = loss_action_pkg::irq_width;

  logic                          rst_meta;
  logic                          rst_sync_n;
  logic [2:0]                    rx_sync;
  logic [1:0]                    fault_sync;
  logic [1:0]                    src_sync;
  logic [1:0]                    mode_sync;
  logic [1:0]                    policy;
  logic [4:0]                    comm_loss_action_select;
  logic [31:0]                   wdog_limit;
  logic [31:0]                   wdog_count;
  logic [31:0]                   last_data;
  logic [4:0]                    param_sel;
  logic [irq_width_c-1:0]        irq_stat;
  logic [irq_width_c-1:0]        irq_mask;
  logic [irq_width_c-1:0]        irq_set;
  loss_action_pkg::conn_state_t  state;
  logic                          loss_latched;
  logic                          src_at_loss;
  logic                          mode_at_loss;
  logic                          rx_pulse;
  logic                          fault_now;
  logic                          expiry;
  logic                          loss_event;
  logic                          conn_reset;
  logic                          fault_seen;
  loss_action_pkg::drive_cmd_t   next_drive_cmd;

  function automatic loss_action_pkg::drive_cmd_t unpack_data(input logic [31:0] d);
    loss_action_pkg::drive_cmd_t c;
    c.cmd_word      = d[15:0];
    c.freq_cmd      = d[31:16];
    c.run           = d[0];
    c.stop          = ~d[0];
    c.emergency_off = d[1];
    c.preset_valid  = 1'b0;
    c.preset_index  = 4'h0;
    return c;
  endfunction : unpack_data

  function automatic logic [15:0] param_word(input logic [4:0] n, input logic [29*16-1:0] v);
    logic [15:0] w;
    w = 16'h0000;
    if (n >= loss_action_pkg::param_first && n <= loss_action_pkg::param_last) begin
      w = v[(32'(n) - 1) * 16 +: 16];
    end
    return w;
  endfunction : param_word

  // The reset is released through two flops so that release is synchronous everywhere.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_sync    <= 3'h0;
      fault_sync <= 2'h0;
      src_sync   <= 2'h0;
      mode_sync  <= 2'h0;
    end else begin
      rx_sync    <= {rx_sync[1:0], net_rx_strobe};
      fault_sync <= {fault_sync[0], net_fatal_fault};
      src_sync   <= {src_sync[0], net_is_cmd_source};
      mode_sync  <= {mode_sync[0], option_cmd_mode};
    end
  end

  // Data is assumed stable around the strobe, so it is sampled on the synchronised edge.
  assign rx_pulse  = rx_sync[1] & ~rx_sync[2];
  assign fault_now = fault_sync[1];
  assign expiry    = (state == loss_action_pkg::conn_established) && (wdog_count >= wdog_limit);
  assign conn_reset = reg_write && (reg_addr == loss_action_pkg::ctrl_addr)
                      && reg_wdata[loss_action_pkg::reset_bit];
  // A fault only counts once the link has carried traffic.
  assign loss_event = ((expiry && (policy != loss_action_pkg::policy_restart))
                      || (fault_now && fault_seen)) && !loss_latched;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fault_seen <= 1'b0;
    end else if (rx_pulse) begin
      fault_seen <= 1'b1;
    end
  end

  // Connection state and inactivity timer.
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state      <= loss_action_pkg::conn_established;
      wdog_count <= 32'h0000_0000;
    end else begin
      case (state)
        loss_action_pkg::conn_established: begin
          if (rx_pulse) begin
            wdog_count <= 32'h0000_0000;
          end else if (expiry) begin
            wdog_count <= 32'h0000_0000;
            case (policy)
              loss_action_pkg::policy_timed_out: state <= loss_action_pkg::conn_timed_out;
              loss_action_pkg::policy_delete:    state <= loss_action_pkg::conn_deleted;
              default:                           state <= loss_action_pkg::conn_established;
            endcase
          end else begin
            wdog_count <= wdog_count + 32'h0000_0001;
          end
        end
        loss_action_pkg::conn_timed_out, loss_action_pkg::conn_deleted: begin
          if (conn_reset) begin
            state      <= loss_action_pkg::conn_established;
            wdog_count <= 32'h0000_0000;
          end
        end
        default: begin
          state <= loss_action_pkg::conn_established;
        end
      endcase
    end
  end

  assign conn_state = state;

  // Loss latch: source and mode are captured once; the latch is held until fresh data after recovery.
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      loss_latched <= 1'b0;
      src_at_loss  <= 1'b0;
      mode_at_loss <= 1'b0;
    end else if (loss_event) begin
      loss_latched <= 1'b1;
      src_at_loss  <= src_sync[1];
      mode_at_loss <= mode_sync[1];
    end else if (loss_latched && rx_pulse && !fault_now
                 && state == loss_action_pkg::conn_established) begin
      loss_latched <= 1'b0;
    end
  end

  // The strobe that ends a loss is kept, so the drive never falls back to pre-loss data.
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      last_data <= 32'h0000_0000;
    end else if (rx_pulse && !(loss_latched && fault_now)
                 && state == loss_action_pkg::conn_established) begin
      last_data <= net_data;
    end
  end

  always_comb begin
    next_drive_cmd = unpack_data(last_data);
    if (loss_latched) begin
      if (comm_loss_action_select == loss_action_pkg::act_zero) begin
        next_drive_cmd = unpack_data(32'h0000_0000);
        if (!mode_at_loss) begin
          next_drive_cmd.stop = 1'b0;
        end
      end else if (comm_loss_action_select == loss_action_pkg::act_retain) begin
        next_drive_cmd = unpack_data(last_data);
      end else if (src_at_loss) begin
        if (comm_loss_action_select == loss_action_pkg::act_stop) begin
          next_drive_cmd.run  = 1'b0;
          next_drive_cmd.stop = 1'b1;
        end else if (comm_loss_action_select == loss_action_pkg::act_eoff) begin
          next_drive_cmd.emergency_off = 1'b1;
        end else if (comm_loss_action_select >= loss_action_pkg::act_preset_first
                     && comm_loss_action_select <= loss_action_pkg::act_preset_last) begin
          // Run and stop bits stay as last consumed.
          next_drive_cmd.preset_valid = 1'b1;
          next_drive_cmd.preset_index = 4'(comm_loss_action_select
                                           - loss_action_pkg::act_preset_first + 5'h01);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      drive_cmd        <= '0;
      drive_cmd_active <= 1'b0;
    end else begin
      drive_cmd        <= next_drive_cmd;
      drive_cmd_active <= loss_latched;
    end
  end

  // Configuration registers.
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      policy                        <= loss_action_pkg::policy_reset;
      comm_loss_action_select       <= loss_action_pkg::action_reset;
      emergency_off_behavior_select <= 2'h0;
      bus_off_interrupt_behavior    <= 1'b0;
      wdog_limit                    <= loss_action_pkg::wdog_reset;
      irq_mask                      <= '0;
      param_sel                     <= loss_action_pkg::param_first;
    end else if (reg_write) begin
      case (reg_addr)
        loss_action_pkg::ctrl_addr: begin
          policy                  <= reg_wdata[loss_action_pkg::policy_lsb +: 2];
          // Out-of-range selections are refused and the old value kept.
          if (reg_wdata[loss_action_pkg::action_lsb +: 5] <= loss_action_pkg::act_preset_last) begin
            comm_loss_action_select <= reg_wdata[loss_action_pkg::action_lsb +: 5];
          end
          emergency_off_behavior_select <= reg_wdata[loss_action_pkg::eoff_lsb +: 2];
          bus_off_interrupt_behavior    <= reg_wdata[loss_action_pkg::boi_bit];
        end
        loss_action_pkg::wdog_addr:     wdog_limit <= reg_wdata;
        loss_action_pkg::irq_mask_addr: irq_mask   <= reg_wdata[irq_width_c-1:0];
        loss_action_pkg::param_sel_addr: param_sel <= reg_wdata[4:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky status: a new event wins over a simultaneous write-one clear.
  assign irq_set = {rx_pulse && loss_latched, loss_event, fault_now && fault_seen, expiry};

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_stat <= '0;
    end else if (reg_write && reg_addr == loss_action_pkg::irq_stat_addr) begin
      irq_stat <= (irq_stat & ~reg_wdata[irq_width_c-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        loss_action_pkg::ctrl_addr:     reg_rdata <= {15'h0000, bus_off_interrupt_behavior,
                                                      2'h0, emergency_off_behavior_select,
                                                      3'h0, comm_loss_action_select,
                                                      2'h0, policy};
        loss_action_pkg::wdog_addr:     reg_rdata <= wdog_limit;
        loss_action_pkg::status_addr:   reg_rdata <= {26'h0000000, src_at_loss, fault_now,
                                                      loss_latched, 1'b0, conn_state};
        loss_action_pkg::irq_stat_addr: reg_rdata <= {28'h0000000, irq_stat};
        loss_action_pkg::irq_mask_addr: reg_rdata <= {28'h0000000, irq_mask};
        loss_action_pkg::param_sel_addr: reg_rdata <= {16'h0000, loss_action_pkg::param_class_code,
                                                       3'h0, param_sel};
        loss_action_pkg::param_dat_addr: reg_rdata <= {16'h0000,
                                                       param_word(param_sel, param_values)};
        default:                        reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : network_loss_action_control

// [tb.sv]
// Purpose: Self-checking bench for the network loss action block.
// Assumes: Watchdog limit is cut to 20 cycles by a register write.
// Notes:   The master model supplies consumed data; levels come from the bench.
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] d_run  = 32'h1234_5679;
  localparam logic [31:0] d_idle = 32'h0BB8_00A4;
  logic                        sys_clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic [7:0]                  reg_addr = 8'h00;
  logic [31:0]                 reg_wdata = 32'h0;
  logic                        reg_write = 1'b0;
  logic                        reg_read = 1'b0;
  logic [31:0]                 reg_rdata;
  logic                        irq;
  logic                        go = 1'b0;
  logic [31:0]                 word = 32'h0;
  logic                        net_rx_strobe;
  logic [31:0]                 net_data;
  logic                        fault = 1'b0;
  logic                        src = 1'b1;
  logic                        mode = 1'b1;
  logic [463:0]                pv;
  loss_action_pkg::drive_cmd_t drive_cmd;
  logic                        drive_cmd_active;
  logic [1:0]                  conn_state;
  logic [1:0]                  eoff_mode;
  logic                        bus_off_mode;
  int                          n_fail = 0;
  int                          n_compared = 0;
  always #10 sys_clk = ~sys_clk;
  initial begin
    for (int n = 0; n < 29; n++) pv[n*16 +: 16] = 16'hA000 + 16'(n + 1);
  end
  network_loss_action_control dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .irq, .net_rx_strobe, .net_fatal_fault(fault), .net_data,
    .net_is_cmd_source(src), .option_cmd_mode(mode), .param_values(pv), .drive_cmd,
    .drive_cmd_active, .emergency_off_behavior_select(eoff_mode),
    .bus_off_interrupt_behavior(bus_off_mode),
    .conn_state);
  net_master master (.sys_clk, .go, .word, .net_rx_strobe, .net_data);
  task automatic chk(input logic [39:0] s, input logic [39:0] x);
    n_compared++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk({8'h00, reg_rdata & m}, {8'h00, x});
  endtask : rdc
  task automatic send(input logic [31:0] d);
    @(posedge sys_clk);
    go <= 1'b1;
    word <= d;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
  endtask : send
  function automatic logic [39:0] unpack(input logic [31:0] d);
    unpack = {d[0], ~d[0], d[1], 5'h00, d[31:16], d[15:0]};
  endfunction : unpack
  task automatic loss(input logic [1:0] p, input logic [4:0] a, input logic s,
                      input logic m, input logic [31:0] d);
    src <= s;
    mode <= m;
    wr(loss_action_pkg::ctrl_addr, {23'h0, a, 2'h0, p});
    send(d);
    repeat (30) @(posedge sys_clk);
    #1;
  endtask : loss
  task automatic recover(input logic [1:0] p, input logic [4:0] a, input logic [31:0] d);
    wr(loss_action_pkg::ctrl_addr, {14'h0, 1'b1, 8'h00, a, 2'h0, p});
    send(d);
    chk(40'(conn_state), 40'h0);
    chk(40'(drive_cmd_active), 40'h0);
    chk(drive_cmd, unpack(d));
  endtask : recover
  task automatic s_regs();
    int ns[4] = '{0, 1, 29, 30};
    rdc(loss_action_pkg::wdog_addr, 32'hFFFFFFFF, loss_action_pkg::wdog_reset);
    rdc(loss_action_pkg::ctrl_addr, 32'h3FFFF, 32'h0);
    wr(loss_action_pkg::ctrl_addr, 32'h130);
    rdc(loss_action_pkg::ctrl_addr, 32'h1F0, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'hFFFFFFFF, 32'h0);
    wr(loss_action_pkg::ctrl_addr, 32'h0001_3021);
    rdc(loss_action_pkg::ctrl_addr, 32'h3FFFF, 32'h0001_3021);
    chk(40'({eoff_mode, bus_off_mode}), 40'h7);
    rdc(loss_action_pkg::param_sel_addr, 32'hFF00, {16'h0, loss_action_pkg::param_class_code, 8'h00});
    foreach (ns[i]) begin
      wr(loss_action_pkg::param_sel_addr, 32'(ns[i]));
      rdc(loss_action_pkg::param_dat_addr, 32'hFFFF, (ns[i] inside {[1:29]}) ? 32'hA000 + 32'(ns[i]) : 32'h0);
    end
  endtask : s_regs
  task automatic s_zero();
    loss(2'h0, 5'h00, 1'b1, 1'b1, d_run);
    chk(40'(conn_state), 40'h1);
    chk(drive_cmd, 40'h40_0000_0000);
    rdc(loss_action_pkg::status_addr, 32'h3B, 32'h29);
    chk(40'(irq), 40'h1);
    rdc(loss_action_pkg::irq_stat_addr, 32'h5, 32'h5);
    wr(loss_action_pkg::irq_mask_addr, 32'h0);
    #1 chk(40'(irq), 40'h0);
    wr(loss_action_pkg::irq_mask_addr, 32'hF);
    wr(loss_action_pkg::irq_stat_addr, 32'hF);
    #1 chk(40'(irq), 40'h0);
    recover(2'h0, 5'h00, d_run);
    loss(2'h0, 5'h00, 1'b1, 1'b0, d_run);
    chk(drive_cmd, 40'h0);
    recover(2'h0, 5'h00, d_run);
  endtask : s_zero
  task automatic s_actions();
    loss(2'h1, 5'h01, 1'b1, 1'b1, d_idle);
    chk(40'(conn_state), 40'h2);
    chk(drive_cmd, unpack(d_idle));
    recover(2'h1, 5'h01, d_run);
    loss(2'h0, 5'h02, 1'b1, 1'b1, d_run);
    chk(40'({drive_cmd.run, drive_cmd.stop}), 40'h1);
    recover(2'h0, 5'h02, d_run);
    loss(2'h0, 5'h03, 1'b1, 1'b1, d_run);
    chk(40'(drive_cmd.emergency_off), 40'h1);
    recover(2'h0, 5'h03, d_run);
    loss(2'h0, 5'h03, 1'b0, 1'b1, d_run);
    chk(40'(drive_cmd.emergency_off), 40'h0);
    recover(2'h0, 5'h03, d_run);
  endtask : s_actions
  task automatic s_presets();
    logic [31:0] d;
    for (int a = 4; a <= 18; a++) begin
      d = a[0] ? d_run : d_idle;
      loss(2'h0, 5'(a), 1'b1, 1'b1, d);
      chk(40'({drive_cmd.preset_valid, drive_cmd.preset_index, drive_cmd.run}),
          40'({1'b1, 4'(a - 3), d[0]}));
      recover(2'h0, 5'(a), d_run);
    end
  endtask : s_presets
  task automatic s_restart_fault();
    loss(2'h2, 5'h02, 1'b1, 1'b1, d_idle);
    chk(40'(conn_state), 40'h0);
    chk(40'(drive_cmd_active), 40'h0);
    chk(drive_cmd, unpack(d_idle));
    fault <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 chk(40'(drive_cmd_active), 40'h1);
    rdc(loss_action_pkg::status_addr, 32'h10, 32'h10);
    rdc(loss_action_pkg::irq_stat_addr, 32'h2, 32'h2);
    fault <= 1'b0;
    recover(2'h2, 5'h02, d_run);
  endtask : s_restart_fault
  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    s_regs();
    // The long reset limit keeps the first wait harmless until data has arrived.
    send(d_idle);
    wr(loss_action_pkg::wdog_addr, 32'd20);
    wr(loss_action_pkg::irq_mask_addr, 32'hF);
    s_zero();
    s_actions();
    s_presets();
    s_restart_fault();
    conclude();
  end
  initial begin
    #200_000;
    n_fail++;
    conclude();
  end
endmodule : tb
bind network_loss_action_control loss_action_sva chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .net_rx_strobe(net_rx_strobe),
  .drive_cmd(drive_cmd), .drive_cmd_active(drive_cmd_active), .conn_state(conn_state));
